/* hw/api_frame_pkg.sv */
/*
  constants shared by the api status frame builder and its byte sender:
  frame types, status codes, field offsets, register map.
  assumes one byte-wide serial stream towards the host controller.
*/
package api_frame_pkg;
  // ****************************************
  // framing
  // ****************************************
  localparam logic [7:0] DELIM_BYTE     = 8'h7e;
  localparam logic [7:0] LEN_MSB        = 8'h00;
  localparam logic [7:0] CSUM_BASE      = 8'hff;
  localparam int         FRAME_HDR      = 3;
  localparam int         BODY_MAX       = 32;
  localparam int         IDX_W          = 5;
  // ****************************************
  // frame types and request types
  // ****************************************
  localparam logic [7:0] TYPE_TX_STATUS = 8'h89;
  localparam logic [7:0] TYPE_MODEM     = 8'h8a;
  localparam logic [7:0] TYPE_TX_COMPAT = 8'h8b;
  localparam logic [7:0] TYPE_IO_SAMPLE = 8'h8f;
  localparam logic [7:0] REQ_COMPAT_A   = 8'h10;
  localparam logic [7:0] REQ_COMPAT_B   = 8'h11;
  // ****************************************
  // status codes
  // ****************************************
  localparam logic [7:0] MODEM_POWER_UP = 8'h00;
  localparam logic [7:0] MODEM_WATCHDOG = 8'h01;
  localparam logic [7:0] MODEM_JOINED   = 8'h02;
  localparam logic [7:0] MODEM_LOST_AP  = 8'h03;
  localparam logic [7:0] MODEM_MGMT_UP  = 8'h0e;
  localparam logic [7:0] MODEM_MGMT_DN  = 8'h0f;
  localparam logic [7:0] DLV_SUCCESS    = 8'h00;
  localparam logic [7:0] DLV_PURGED     = 8'h03;
  localparam logic [7:0] DLV_PHY_ERR    = 8'h04;
  localparam logic [7:0] DLV_ACK_TMO    = 8'h21;
  localparam logic [7:0] DLV_NO_RES     = 8'h32;
  localparam logic [7:0] DLV_TOO_LONG   = 8'h74;
  localparam logic [7:0] DLV_SOCK_FAIL  = 8'h76;
  // ****************************************
  // lengths, fixed bytes, field offsets
  // ****************************************
  localparam logic [7:0] LEN_TX_STATUS  = 8'h03;
  localparam logic [7:0] LEN_MODEM      = 8'h02;
  localparam logic [7:0] LEN_COMPAT     = 8'h07;
  localparam logic [7:0] LEN_SMP_BASE   = 8'h0f;
  localparam logic [7:0] CPT_RSVD0      = 8'hff;
  localparam logic [7:0] CPT_RSVD1      = 8'hfe;
  localparam logic [7:0] CPT_RSVD_ZERO  = 8'h00;
  localparam logic [7:0] SMP_SET_COUNT  = 8'h01;
  localparam int OFS_TYPE = 3, OFS_FRAME_ID = 4, OFS_TXS_STATUS = 5, OFS_MODEM_CODE = 4;
  localparam int OFS_CPT_RSVD = 5, OFS_CPT_STATUS = 8, OFS_CPT_RSVD_LAST = 9;
  localparam int OFS_SRC_ADDR = 4, OFS_STRENGTH = 12, OFS_OPTIONS = 13, OFS_SET_COUNT = 14;
  localparam int OFS_DMASK = 15, OFS_AMASK = 17, OFS_DSAMPLE = 18;
  localparam int ADDR_BYTES = 8, IP_BYTES = 4, ANALOG_INPUTS = 4, AMASK_SUPPLY_BIT = 7;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_STAT     = 8'h04;
  localparam logic [7:0]  REG_INT_STAT = 8'h08;
  localparam logic [7:0]  REG_INT_MASK = 8'h0c;
  localparam int          CTRL_API_BIT = 0;
  localparam logic        CTRL_API_RST = 1'b1;
  localparam int          INT_W = 3, INT_SENT = 0, INT_SUPPRESS = 1, INT_DROP = 2;
  localparam logic [2:0]  INT_MASK_RST = 3'h0;

  // frame offset to index into the stored frame body
  function automatic int bi(input int ofs);
    return ofs - FRAME_HDR;
  endfunction
endpackage

/* hw/api_status_frame_builder.sv */
/*
  api status frame builder: turns transmit results, modem events and remote
  io samples into outbound api frames, with a small register and irq block.
  assumes event sources hold valid until ready, and a byte sink with ready.
*/
// Notes on behaviour
// [RL1] successful transmit gives type 89 frame: length 3, id, status, checksum
// [RL2] modem status frame type 8a carries one status code byte
// [RL3] after power-up a modem status frame with code zero goes first
// [RL4] requests of type 10 or 11 get the 8b status frame, others 89
// [RL5] 8b frame: length 7, id, three reserved, delivery status, one reserved
// [RL6] delivery status codes pass through from the transmit result
// [RL7] remote io sample gives type 8f frame, only in api mode
// [RL8] sample source address: four zero bytes then the ip address
// [RL9] link margin strength at 12, receive options at 13
// [RL10] sample set count at 14 is always one
// [RL11] sixteen bit digital mask at 15 and 16, high byte first
// [RL12] analog mask byte at 17, top bit flags supply sample
// [RL13] two digital sample bytes only when digital mask nonzero, masked
// [RL14] each enabled analog input adds two bytes, input 0 first
// [RL15] frame id zero suppresses the transmit status frame
// [RL16] delimiter, big-endian length, body, checksum ff minus byte sum
// [RL17] supply sample appended after analog values when mask top bit set
`timescale 1ns/1ps
module api_status_frame_builder
  import api_frame_pkg::*;
(
  input  wire logic             ref_clk_i,
  input  wire logic             reset_i,
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic [31:0]      reg_wdata_i,
  input  wire logic             reg_wr_i,
  input  wire logic             reg_rd_i,
  output logic      [31:0]      reg_rdata_o,
  output logic                  irq_o,
  input  wire logic             txs_valid_i,
  output logic                  txs_ready_o,
  input  wire logic [7:0]       txs_frame_id_i,
  input  wire logic [7:0]       txs_req_type_i,
  input  wire logic [7:0]       txs_status_i,
  input  wire logic             mdm_valid_i,
  output logic                  mdm_ready_o,
  input  wire logic [7:0]       mdm_code_i,
  input  wire logic             smp_valid_i,
  output logic                  smp_ready_o,
  input  wire logic [31:0]      smp_ip_i,
  input  wire logic [7:0]       smp_strength_i,
  input  wire logic [7:0]       smp_options_i,
  input  wire logic [15:0]      smp_dmask_i,
  input  wire logic [7:0]       smp_amask_i,
  input  wire logic [15:0]      smp_dsample_i,
  input  wire logic [3:0][15:0] smp_analog_i,
  input  wire logic [15:0]      smp_supply_i,
  output logic      [7:0]       out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  typedef enum logic [2:0] {SRC_NONE, SRC_PU, SRC_TXS, SRC_MDM, SRC_SMP} src_e;

  frame_if fr ();

  logic             start_r;
  logic [7:0]       len_r;
  logic [7:0]       body_r [BODY_MAX];
  logic             pu_pend_r;
  logic             api_mode_r;
  logic [INT_W-1:0] int_stat_r;
  logic [INT_W-1:0] int_mask_r;
  logic [31:0]      rdata_r;
  logic [7:0]       body_n [BODY_MAX];
  logic [7:0]       len_n;
  logic [INT_W-1:0] int_stat_nxt;

  // ****************************************
  // arbitration
  // ****************************************
  // one frame at a time; power-up frame outranks everything, then transmit
  // results, modem events, samples. sources simply wait on ready.
  wire  idle_w      = !fr.busy && !start_r;
  wire  txs_compat  = (txs_req_type_i == REQ_COMPAT_A) || (txs_req_type_i == REQ_COMPAT_B);
  wire  txs_fire    = txs_valid_i && txs_ready_o;
  wire  mdm_fire    = mdm_valid_i && mdm_ready_o;
  wire  smp_fire    = smp_valid_i && smp_ready_o;
  wire  txs_emit    = txs_fire && (txs_frame_id_i != 8'h00);
  wire  smp_emit    = smp_fire && api_mode_r;
  assign txs_ready_o = idle_w && !pu_pend_r; // RL3
  assign mdm_ready_o = idle_w && !pu_pend_r && !txs_valid_i;
  assign smp_ready_o = idle_w && !pu_pend_r && !txs_valid_i && !mdm_valid_i;
  src_e src_w;
  assign src_w = (idle_w && pu_pend_r) ? SRC_PU  : // RL3
                 txs_emit              ? SRC_TXS : // RL15
                 mdm_fire              ? SRC_MDM :
                 smp_emit              ? SRC_SMP : SRC_NONE; // RL7
  wire  load_w = (src_w != SRC_NONE);

  // ****************************************
  // frame body composition
  // ****************************************
  // body index 0 is the frame type; everything after the length field.
  always_comb begin
    int p;
    p = 0;
    for (int i = 0; i < BODY_MAX; i++) begin
      body_n[i] = 8'h00;
    end
    len_n = 8'h00;
    case (src_w)
      SRC_PU: begin
        body_n[bi(OFS_TYPE)]       = TYPE_MODEM; // RL3
        body_n[bi(OFS_MODEM_CODE)] = MODEM_POWER_UP;
        len_n                      = LEN_MODEM;
      end
      SRC_TXS: begin
        body_n[bi(OFS_FRAME_ID)] = txs_frame_id_i;
        if (txs_compat) begin
          body_n[bi(OFS_TYPE)]          = TYPE_TX_COMPAT; // RL4
          body_n[bi(OFS_CPT_RSVD)]      = CPT_RSVD0; // RL5
          body_n[bi(OFS_CPT_RSVD) + 1]  = CPT_RSVD1;
          body_n[bi(OFS_CPT_RSVD) + 2]  = CPT_RSVD_ZERO;
          body_n[bi(OFS_CPT_STATUS)]    = txs_status_i; // RL6
          body_n[bi(OFS_CPT_RSVD_LAST)] = CPT_RSVD_ZERO;
          len_n                         = LEN_COMPAT;
        end else begin
          body_n[bi(OFS_TYPE)]       = TYPE_TX_STATUS; // RL1
          body_n[bi(OFS_TXS_STATUS)] = txs_status_i; // RL6
          len_n                      = LEN_TX_STATUS;
        end
      end
      SRC_MDM: begin
        body_n[bi(OFS_TYPE)]       = TYPE_MODEM; // RL2
        body_n[bi(OFS_MODEM_CODE)] = mdm_code_i;
        len_n                      = LEN_MODEM;
      end
      SRC_SMP: begin
        body_n[bi(OFS_TYPE)] = TYPE_IO_SAMPLE;
        // upper address bytes stay zero from the default above
        for (int i = 0; i < IP_BYTES; i++) begin
          body_n[bi(OFS_SRC_ADDR) + ADDR_BYTES - IP_BYTES + i] = smp_ip_i[31 - 8*i -: 8]; // RL8
        end
        body_n[bi(OFS_STRENGTH)]  = smp_strength_i; // RL9
        body_n[bi(OFS_OPTIONS)]   = smp_options_i;
        body_n[bi(OFS_SET_COUNT)] = SMP_SET_COUNT; // RL10
        body_n[bi(OFS_DMASK)]     = smp_dmask_i[15:8]; // RL11
        body_n[bi(OFS_DMASK) + 1] = smp_dmask_i[7:0];
        body_n[bi(OFS_AMASK)]     = smp_amask_i; // RL12
        p = bi(OFS_DSAMPLE);
        if (smp_dmask_i != 16'h0000) begin
          // lines without sampling read as zero
          body_n[p]     = smp_dsample_i[15:8] & smp_dmask_i[15:8]; // RL13
          body_n[p + 1] = smp_dsample_i[7:0] & smp_dmask_i[7:0];
          p = p + 2;
        end
        for (int k = 0; k < ANALOG_INPUTS; k++) begin
          if (smp_amask_i[k]) begin
            body_n[p]     = smp_analog_i[k][15:8]; // RL14
            body_n[p + 1] = smp_analog_i[k][7:0];
            p = p + 2;
          end
        end
        if (smp_amask_i[AMASK_SUPPLY_BIT]) begin
          body_n[p]     = smp_supply_i[15:8]; // RL17
          body_n[p + 1] = smp_supply_i[7:0];
          p = p + 2;
        end
        len_n = 8'(p);
      end
      default: len_n = 8'h00;
    endcase
  end

  // body is frozen from load until the sender returns to idle
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      start_r <= 1'b0;
      len_r   <= 8'h00;
      for (int i = 0; i < BODY_MAX; i++) begin
        body_r[i] <= 8'h00;
      end
    end else begin
      start_r <= load_w;
      if (load_w) begin
        len_r  <= len_n;
        body_r <= body_n;
      end
    end
  end

  // power-up frame owed from reset until it is loaded
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      pu_pend_r <= 1'b1;
    end else if (src_w == SRC_PU) begin
      pu_pend_r <= 1'b0; // RL3
    end
  end

  assign fr.start    = start_r;
  assign fr.body_len = len_r;
  assign fr.rd_byte  = body_r[fr.rd_idx];

  frame_tx u_tx (
    .ref_clk_i   (ref_clk_i),
    .reset_i     (reset_i),
    .fr          (fr.sender),
    .out_data_o  (out_data_o),
    .out_valid_o (out_valid_o),
    .out_ready_i (out_ready_i)
  );

  // ****************************************
  // registers and interrupt
  // ****************************************
  wire              wr_ctrl   = reg_wr_i && (reg_addr_i == REG_CTRL);
  wire              wr_mask   = reg_wr_i && (reg_addr_i == REG_INT_MASK);
  wire              rd_clr    = reg_rd_i && (reg_addr_i == REG_INT_STAT);
  wire [INT_W-1:0]  int_evt_w = {smp_fire && !api_mode_r,
                                 txs_fire && (txs_frame_id_i == 8'h00),
                                 fr.done};
  // a new event in the clearing read's cycle survives the clear
  assign int_stat_nxt = (rd_clr ? '0 : int_stat_r) | int_evt_w;
  wire [31:0] rsel_w = (reg_addr_i == REG_CTRL)     ? {31'h0, api_mode_r} :
                       (reg_addr_i == REG_STAT)     ? {30'h0, pu_pend_r, fr.busy} :
                       (reg_addr_i == REG_INT_STAT) ? {29'h0, int_stat_r} :
                       (reg_addr_i == REG_INT_MASK) ? {29'h0, int_mask_r} : 32'h0;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      api_mode_r <= CTRL_API_RST;
      int_mask_r <= INT_MASK_RST;
      int_stat_r <= '0;
      rdata_r    <= 32'h0;
    end else begin
      if (wr_ctrl) api_mode_r <= reg_wdata_i[CTRL_API_BIT];
      if (wr_mask) int_mask_r <= reg_wdata_i[INT_W-1:0];
      int_stat_r <= int_stat_nxt;
      rdata_r    <= reg_rd_i ? rsel_w : 32'h0;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign irq_o       = |(int_stat_r & int_mask_r);

  // ****************************************
  // checks
  // ****************************************
  a_pu_goes_first: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RL3
    (load_w && pu_pend_r) |=> (body_r[0] == TYPE_MODEM && body_r[1] == MODEM_POWER_UP
                               && len_r == LEN_MODEM))
    else $error("power-up frame not first");
  a_zero_id_quiet: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RL15
    (txs_fire && txs_frame_id_i == 8'h00) |=> !start_r)
    else $error("status frame sent for id zero");
  a_txs_plain: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RL1
    (txs_emit && !txs_compat) |=> (start_r && len_r == LEN_TX_STATUS
      && body_r[0] == TYPE_TX_STATUS && body_r[1] == $past(txs_frame_id_i)
      && body_r[2] == $past(txs_status_i)))
    else $error("bad transmit status frame");
  a_txs_compat: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RL4
    (txs_emit && txs_compat) |=> (len_r == LEN_COMPAT && body_r[0] == TYPE_TX_COMPAT
      && body_r[bi(OFS_CPT_STATUS)] == $past(txs_status_i)))
    else $error("bad compatibility status frame");
  a_modem_code: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RL2
    (mdm_fire) |=> (body_r[0] == TYPE_MODEM && body_r[1] == $past(mdm_code_i)))
    else $error("modem code not carried");
  a_smp_dropped: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RL7
    (smp_fire && !api_mode_r) |=> (!start_r && int_stat_r[INT_DROP]))
    else $error("sample sent outside api mode");
  a_smp_header: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RL8
    (smp_emit) |=> (body_r[1] == 8'h00 && body_r[4] == 8'h00
      && body_r[5] == $past(smp_ip_i[31:24]) && body_r[8] == $past(smp_ip_i[7:0])
      && body_r[bi(OFS_SET_COUNT)] == SMP_SET_COUNT
      && body_r[bi(OFS_AMASK)] == $past(smp_amask_i)))
    else $error("bad sample header");
  a_smp_length: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RL14
    (smp_emit) |=> (len_r == 8'(int'(LEN_SMP_BASE) + 2*int'($past(smp_dmask_i) != 16'h0)
      + 2*$countones($past(smp_amask_i[3:0])) + 2*int'($past(smp_amask_i[7])))))
    else $error("sample length wrong");
  a_irq_follows: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (fr.done && int_mask_r[INT_SENT] && !wr_mask) |=> irq_o)
    else $error("sent interrupt missing");
  c_pu_frame: cover property (@(posedge ref_clk_i) disable iff (reset_i)
    (src_w == SRC_PU) ##[1:100] fr.done);
  c_compat: cover property (@(posedge ref_clk_i) disable iff (reset_i) (txs_emit && txs_compat));
  c_smp_supply: cover property (@(posedge ref_clk_i) disable iff (reset_i)
    (smp_emit && smp_amask_i[AMASK_SUPPLY_BIT] && smp_dmask_i != 16'h0));
  c_clear_race: cover property (@(posedge ref_clk_i) disable iff (reset_i) (rd_clr && |int_evt_w));
endmodule

/* hw/frame_if.sv */
/*
  link between the frame builder and the byte sender.
  assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
interface frame_if;
  import api_frame_pkg::*;
  logic             start;
  logic [7:0]       body_len;
  logic [IDX_W-1:0] rd_idx;
  logic [7:0]       rd_byte;
  logic             busy;
  logic             done;
  modport builder (output start, body_len, rd_byte, input rd_idx, busy, done);
  modport sender  (input start, body_len, rd_byte, output rd_idx, busy, done);
endinterface

/* hw/frame_tx.sv */
/*
  byte sender: delimiter, length, stored body, checksum, under back-pressure.
  assumes the body stays stable while busy is high.
*/
`timescale 1ns/1ps
module frame_tx
  import api_frame_pkg::*;
(
  input  wire logic  ref_clk_i,
  input  wire logic  reset_i,
  frame_if.sender    fr,
  output logic [7:0] out_data_o,
  output logic       out_valid_o,
  input  wire logic  out_ready_i
);
  typedef enum logic [2:0] {S_IDLE, S_LEN_HI, S_LEN_LO, S_BODY, S_CSUM, S_LAST} tx_state_e;
  tx_state_e        state_r;
  logic [7:0]       data_r;
  logic             valid_r;
  logic [IDX_W-1:0] idx_r;
  logic [7:0]       sum_r;
  logic             done_r;
  wire              adv_w  = valid_r & out_ready_i;
  wire              last_w = ({3'h0, idx_r} == (fr.body_len - 8'h01));

  // handshake and status towards the builder
  assign fr.rd_idx   = idx_r;
  assign fr.busy     = (state_r != S_IDLE);
  assign fr.done     = done_r;
  assign out_data_o  = data_r;
  assign out_valid_o = valid_r;

  // next byte is loaded only once the current one is taken
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_r <= S_IDLE;
      data_r  <= 8'h00;
      valid_r <= 1'b0;
      idx_r   <= '0;
      sum_r   <= 8'h00;
      done_r  <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        S_IDLE: if (fr.start) begin
          data_r  <= DELIM_BYTE; // RL16
          valid_r <= 1'b1;
          idx_r   <= '0;
          sum_r   <= 8'h00;
          state_r <= S_LEN_HI;
        end
        S_LEN_HI: if (adv_w) begin
          data_r  <= LEN_MSB; // RL16
          state_r <= S_LEN_LO;
        end
        S_LEN_LO: if (adv_w) begin
          data_r  <= fr.body_len;
          state_r <= S_BODY;
        end
        S_BODY: if (adv_w) begin
          data_r  <= fr.rd_byte;
          sum_r   <= sum_r + fr.rd_byte; // RL16
          idx_r   <= idx_r + 5'h01;
          state_r <= last_w ? S_CSUM : S_BODY;
        end
        S_CSUM: if (adv_w) begin
          data_r  <= CSUM_BASE - sum_r; // RL16
          state_r <= S_LAST;
        end
        S_LAST: if (adv_w) begin
          valid_r <= 1'b0;
          done_r  <= 1'b1;
          state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_delim_first: assert property (@(posedge ref_clk_i) disable iff (reset_i) // RL16
    (state_r == S_IDLE && fr.start) |=> (valid_r && data_r == DELIM_BYTE))
    else $error("frame did not open with delimiter");
  a_byte_held: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (valid_r && !out_ready_i) |=> (valid_r && $stable(data_r)))
    else $error("byte changed while stalled");
  c_stall: cover property (@(posedge ref_clk_i) disable iff (reset_i)
    (state_r == S_BODY && valid_r && !out_ready_i));
endmodule

/* verif/api_status_frame_builder_tb.sv */
/*
  self-checking bench for the api status frame builder.
  assumes the host byte sink model and the design files are compiled first.
*/
`timescale 1ns/1ps
module api_status_frame_builder_tb;
  import api_frame_pkg::*;
  logic             ref_clk_i      = 1'b0;
  logic             reset_i        = 1'b1;
  logic [7:0]       reg_addr_i     = 8'h00;
  logic [31:0]      reg_wdata_i    = 32'h0;
  logic             reg_wr_i       = 1'b0;
  logic             reg_rd_i       = 1'b0;
  logic             txs_valid_i    = 1'b0;
  logic             mdm_valid_i    = 1'b0;
  logic             smp_valid_i    = 1'b0;
  logic [7:0]       txs_frame_id_i = 8'h00;
  logic [7:0]       txs_req_type_i = 8'h00;
  logic [7:0]       txs_status_i   = 8'h00;
  logic [7:0]       mdm_code_i     = 8'h00;
  logic [31:0]      smp_ip_i       = 32'hc0a80067;
  logic [7:0]       smp_strength_i = 8'h2e;
  logic [7:0]       smp_options_i  = 8'h00;
  logic [15:0]      smp_dmask_i    = 16'h0;
  logic [7:0]       smp_amask_i    = 8'h00;
  logic [15:0]      smp_dsample_i  = 16'hf00f;
  logic [3:0][15:0] smp_analog_i   = {16'h13a3, 16'h12a2, 16'h11a1, 16'h10a0};
  logic [15:0]      smp_supply_i   = 16'h0c9a;
  logic             stall          = 1'b0;
  logic [31:0]      reg_rdata_o;
  logic             irq_o, txs_ready_o, mdm_ready_o, smp_ready_o, out_valid_o, host_ready;
  logic [7:0]       out_data_o;
  int               miscompares    = 0;
  int               total_checks   = 0;

  // ****************************************
  // design, host model, clock
  // ****************************************
  api_status_frame_builder i_dut (
    .ref_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .irq_o, .txs_valid_i, .txs_ready_o, .txs_frame_id_i, .txs_req_type_i, .txs_status_i,
    .mdm_valid_i, .mdm_ready_o, .mdm_code_i, .smp_valid_i, .smp_ready_o, .smp_ip_i,
    .smp_strength_i, .smp_options_i, .smp_dmask_i, .smp_amask_i, .smp_dsample_i,
    .smp_analog_i, .smp_supply_i, .out_data_o, .out_valid_o, .out_ready_i(host_ready));
  host_byte_sink i_host (.ref_clk_i, .reset_i, .data_i(out_data_o), .valid_i(out_valid_o),
    .stall_i(stall), .ready_o(host_ready));
  always #2 ref_clk_i = ~ref_clk_i;

  // ****************************************
  // compare, bus and handshake tasks
  // ****************************************
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    {reg_rd_i, reg_addr_i} <= {1'b1, a};
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  // ready is looked at on the falling edge, where it has settled
  task automatic fire(input int src);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    {txs_valid_i, mdm_valid_i, smp_valid_i} <= 3'b100 >> src;
    @(negedge ref_clk_i);
    while (!(src == 0 ? txs_ready_o : src == 1 ? mdm_ready_o : smp_ready_o) && n < 900) begin
      @(negedge ref_clk_i);
      n++;
    end
    @(posedge ref_clk_i);
    {txs_valid_i, mdm_valid_i, smp_valid_i} <= 3'b000;
  endtask
  // wraps the body in delimiter, length and checksum, then takes it from the host
  task automatic expect_frame(input logic [7:0] body[$]);
    logic [7:0] exp[$];
    logic [7:0] sum;
    int         n;
    sum = 8'h00;
    n = 0;
    foreach (body[i]) sum += body[i];
    exp = {8'h7e, 8'h00, 8'(body.size()), body, 8'(8'hff - sum)};
    while (i_host.got_q.size() < exp.size() && n < 900) begin
      @(posedge ref_clk_i);
      n++;
    end
    foreach (exp[i]) chk8("frame byte", exp[i], i_host.got_q.size() ? i_host.got_q.pop_front() : 8'hxx);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_power_up();
    {txs_frame_id_i, txs_req_type_i, txs_status_i} <= 24'h052003;
    fire(0);
    expect_frame('{8'h8a, 8'h00});
    expect_frame('{8'h89, 8'h05, 8'h03});
  endtask
  task automatic t_regs();
    logic [31:0] d;
    reg_rd(8'h00, d);
    chk32("ctrl reset", 32'h1, d);
    reg_rd(8'h0c, d);
    chk32("mask reset", 32'h0, d);
    // sent status is still set from the first two frames, so the mask raises irq
    reg_wr(8'h0c, 32'h1);
    reg_rd(8'h0c, d);
    chk32("mask write", 32'h1, d);
    chk32("irq on sent", 32'h1, {31'h0, irq_o});
    reg_rd(8'h10, d);
    chk32("unmapped read", 32'h0, d);
  endtask
  task automatic t_tx_status();
    logic [7:0] st[7] = '{8'h00, 8'h03, 8'h04, 8'h21, 8'h32, 8'h74, 8'h76};
    logic [7:0] rt[3] = '{8'h10, 8'h11, 8'h20};
    logic [31:0] d;
    foreach (st[i]) begin
      {txs_frame_id_i, txs_req_type_i, txs_status_i} <= {8'(i + 1), rt[i % 3], st[i]};
      fire(0);
      // frame is in flight two edges after the accept, status shows busy only
      reg_rd(8'h04, d);
      chk32("busy while sending", 32'h1, d);
      if (i % 3 == 2) expect_frame('{8'h89, 8'(i + 1), st[i]});
      else expect_frame('{8'h8b, 8'(i + 1), 8'hff, 8'hfe, 8'h00, st[i], 8'h00});
    end
  endtask
  task automatic t_modem();
    logic [7:0] cd[6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0e, 8'h0f};
    foreach (cd[i]) begin
      mdm_code_i <= cd[i];
      fire(1);
      expect_frame('{8'h8a, cd[i]});
    end
  endtask
  // host stalls meanwhile, so bytes must be held
  task automatic t_samples();
    logic [15:0] dm[3] = '{16'h0100, 16'h0000, 16'h1c3f};
    logic [7:0]  am[3] = '{8'h81, 8'h0d, 8'h00};
    logic [7:0]  b[$];
    stall <= 1'b1;
    foreach (dm[i]) begin
      {smp_dmask_i, smp_amask_i} <= {dm[i], am[i]};
      fire(2);
      b = '{8'h8f, 8'h00, 8'h00, 8'h00, 8'h00, 8'hc0, 8'ha8, 8'h00, 8'h67, 8'h2e, 8'h00, 8'h01};
      b = {b, dm[i][15:8], dm[i][7:0], am[i]};
      if (dm[i] != 16'h0) b = {b, dm[i][15:8] & 8'hf0, dm[i][7:0] & 8'h0f};
      for (int k = 0; k < 4; k++) if (am[i][k]) b = {b, 8'(8'h10 + k), 8'(8'ha0 + k)};
      if (am[i][7]) b = {b, 8'h0c, 8'h9a};
      expect_frame(b);
    end
    stall <= 1'b0;
  endtask
  // no frame for id zero or for samples outside api mode; status shows both, irq only the id zero one
  task automatic t_irq();
    logic [31:0] d;
    reg_rd(8'h08, d);
    reg_wr(8'h0c, 32'h2);
    {txs_frame_id_i, txs_req_type_i} <= 16'h0020;
    fire(0);
    reg_wr(8'h00, 32'h0);
    fire(2);
    repeat (30) @(posedge ref_clk_i);
    chk32("bytes sent", 32'h0, i_host.got_q.size());
    chk32("irq raised", 32'h1, {31'h0, irq_o});
    reg_rd(8'h08, d);
    chk32("int status", 32'h6, d);
    chk32("irq cleared", 32'h0, {31'h0, irq_o});
    reg_wr(8'h00, 32'h1);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // watchdog: 30000 cycles, far beyond the few hundred cycles the scenarios need
  initial begin
    #120000;
    miscompares++;
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    t_power_up();
    t_regs();
    t_tx_status();
    t_modem();
    t_samples();
    t_irq();
    print_verdict();
  end
endmodule

/* verif/host_byte_sink.sv */
/*
  host controller model at the byte output: takes frame bytes under ready,
  and can stall by dropping ready on every other cycle.
  assumes it shares the frame builder's clock and synchronous reset.
*/
`timescale 1ns/1ps
module host_byte_sink (
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  input  wire logic [7:0] data_i,
  input  wire logic       valid_i,
  input  wire logic       stall_i,
  output logic            ready_o
);
  logic [7:0] got_q[$];
  logic       ready_r;

  assign ready_o = ready_r;

  // stalling toggles ready, so the sender has to hold each byte
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= stall_i ? ~ready_r : 1'b1;
    end
  end

  // a byte counts only on valid and ready at the same edge
  always @(posedge ref_clk_i) begin
    if (!reset_i && valid_i && ready_r) begin
      got_q.push_back(data_i);
    end
  end
endmodule
